// ===== src/adc_select_sync_noise_cancel.sv
// Converter control: selection buffering, start alignment, noise canceler and APB registers
// Summary of operation
// [RULE1] Selections held in CPU-accessible temporary register
// [RULE2] Idle converter copies temporary selection continuously
// [RULE3] Conversion start freezes the active selection
// [RULE4] Copying resumes in final conversion cycle
// [RULE5] Conversion begins on next converter clock edge
// [RULE6] Software waits one cycle before reselecting
// [RULE7] Software waits 125 us after differential change
// [RULE8] Same wait after reference select change
// [RULE9] JTAG enable removes channels four to seven
// [RULE10] Free-running change shows one result later
// [RULE11] Software selects channel before first free-run
// [RULE12] Over-reference single-ended input gives full scale
// [RULE13] Reference from supply, internal or external
// [RULE14] Software prepares converter before noise sleep
// [RULE15] Halted CPU in quiet sleep starts conversion
// [RULE16] Woken CPU still gets completion request
// [RULE17] Other sleep modes leave converter enabled
// [RULE18] Software cycles enable after deep sleep
// [RULE19] Software discards first result after reference switch
// [RULE20] Digital outputs stay quiet during conversion
// [RULE21] Conversion lasts 13 cycles, first 25
// [RULE22] Completion stores result, sets done, clears start
// [RULE23] Reference code 00 external, 01 supply, 11 internal
// [RULE24] Unlocked selection loads on each converter edge (the code loads it on every system clock edge while unlocked)
//
// Added by the designer: the register offsets and the APB interface to the registers.
`default_nettype none
module adc_select_sync_noise_cancel (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [2:0] sleep_mode_in,
    input wire logic cpu_halted_in,
    input wire logic jtag_enable_in,
    input wire logic [9:0] analog_result_in,
    input wire logic above_reference_in,
    output logic [4:0] active_channel_out,
    output logic [1:0] active_reference_out,
    output logic ref_external_out,
    output logic ref_supply_out,
    output logic ref_internal_out,
    output logic mux_connect_out,
    output logic converter_busy_out,
    output logic conv_complete_irq_out
);
    logic [4:0] channel_select_bits;
    logic [1:0] reference_select_bits;
    logic left_adjust;
    logic converter_enable_bit;
    logic conversion_start_bit;
    logic free_running_select_bit;
    logic conversion_done_flag;
    logic complete_irq_enable;
    logic [2:0] prescale_select;
    logic [9:0] result;
    logic [4:0] active_channel;
    logic [1:0] active_reference;
    adc_select_pkg::conv_state_type state;
    logic [4:0] cycle_count;
    logic [4:0] conv_len;
    logic first_pending;
    logic adc_tick;
    logic halted_prev;
    logic [11:0] sync_stage1;
    logic [11:0] sync_stage2;
    logic jtag_sync;
    logic above_sync;
    logic [9:0] analog_sync;
    logic [31:0] next_prdata;
    logic write_sel;
    logic write_ctrl;
    logic busy;
    logic unlocked;
    logic start_now;
    logic complete;
    logic restart;
    logic quiet_sleep;
    logic auto_start;

    function automatic logic is_single_ended(input logic [4:0] ch);
        is_single_ended = (ch <= adc_select_pkg::LAST_PIN_CHANNEL) ||
                          (ch >= adc_select_pkg::FIRST_FIXED_CHANNEL);
    endfunction

    function automatic logic is_jtag_channel(input logic [4:0] ch);
        is_jtag_channel = (ch >= adc_select_pkg::FIRST_JTAG_CHANNEL) &&
                          (ch <= adc_select_pkg::LAST_PIN_CHANNEL);
    endfunction

    adc_clock_prescaler prescaler (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .run_in(converter_enable_bit),
        .divide_select_in(prescale_select),
        .tick_out(adc_tick)
    );

    // Two-stage synchronisers for inputs from outside the clock domain
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync_stage1 <= 12'h000;
            sync_stage2 <= 12'h000;
        end else begin
            sync_stage1 <= {jtag_enable_in, above_reference_in, analog_result_in};
            sync_stage2 <= sync_stage1;
        end
    end
    assign jtag_sync = sync_stage2[11];
    assign above_sync = sync_stage2[10];
    assign analog_sync = sync_stage2[9:0];

    assign busy = (state == adc_select_pkg::CONV_BUSY);
    assign write_sel = psel_in && penable_in && pwrite_in &&
                       (paddr_in == adc_select_pkg::SELECT_OFFSET);
    assign write_ctrl = psel_in && penable_in && pwrite_in &&
                        (paddr_in == adc_select_pkg::CONTROL_OFFSET);
    assign unlocked = !busy || (cycle_count == conv_len); // RULE3 RULE4
    assign start_now = adc_tick && !busy && conversion_start_bit &&
                       converter_enable_bit; // RULE5
    assign complete = adc_tick && busy && (cycle_count == conv_len);
    assign restart = complete && free_running_select_bit;
    assign quiet_sleep = (sleep_mode_in == adc_select_pkg::SLEEP_IDLE) ||
                         (sleep_mode_in == adc_select_pkg::SLEEP_NOISE_REDUCTION);
    assign auto_start = cpu_halted_in && !halted_prev && quiet_sleep &&
                        converter_enable_bit && !busy && !conversion_start_bit &&
                        !free_running_select_bit && complete_irq_enable; // RULE15

    // Temporary selection register, written by software at any time
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            reference_select_bits <= adc_select_pkg::SELECT_RESET[7:6];
            left_adjust <= adc_select_pkg::SELECT_RESET[5];
            channel_select_bits <= adc_select_pkg::SELECT_RESET[4:0];
        end else if (write_sel) begin // RULE1
            reference_select_bits <= pwdata_in[adc_select_pkg::REF_MSB:adc_select_pkg::REF_LSB];
            left_adjust <= pwdata_in[adc_select_pkg::LEFT_ADJUST_BIT];
            channel_select_bits <= pwdata_in[adc_select_pkg::CHANNEL_MSB:0];
        end
    end

    // Active selection follows the temporary one whenever unlocked
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            active_channel <= adc_select_pkg::SELECT_RESET[4:0];
            active_reference <= adc_select_pkg::SELECT_RESET[7:6];
        end else if (unlocked) begin // RULE2 RULE24
            active_channel <= channel_select_bits;
            active_reference <= reference_select_bits;
        end
    end

    // Control bits; sleep never touches the enable bit
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            converter_enable_bit <= adc_select_pkg::CONTROL_RESET[7];
            free_running_select_bit <= adc_select_pkg::CONTROL_RESET[5];
            complete_irq_enable <= adc_select_pkg::CONTROL_RESET[3];
            prescale_select <= adc_select_pkg::CONTROL_RESET[2:0];
        end else if (write_ctrl) begin // RULE17
            converter_enable_bit <= pwdata_in[adc_select_pkg::ENABLE_BIT];
            free_running_select_bit <= pwdata_in[adc_select_pkg::FREE_RUN_BIT];
            complete_irq_enable <= pwdata_in[adc_select_pkg::IRQ_ENABLE_BIT];
            prescale_select <= pwdata_in[adc_select_pkg::PRESCALE_MSB:0];
        end
    end

    // Start bit: set by software or the noise canceler, set wins over clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            conversion_start_bit <= adc_select_pkg::CONTROL_RESET[6];
        end else if ((write_ctrl && pwdata_in[adc_select_pkg::START_BIT] &&
                      pwdata_in[adc_select_pkg::ENABLE_BIT]) || auto_start) begin
            conversion_start_bit <= 1'b1; // RULE15
        end else if (!converter_enable_bit || (complete && !free_running_select_bit)) begin
            conversion_start_bit <= 1'b0; // RULE22
        end
    end

    // Done flag: write one to clear, completion wins over a clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            conversion_done_flag <= adc_select_pkg::CONTROL_RESET[4];
        end else if (complete) begin
            conversion_done_flag <= 1'b1; // RULE16 RULE22
        end else if (write_ctrl && pwdata_in[adc_select_pkg::DONE_BIT]) begin
            conversion_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            halted_prev <= 1'b0;
        end else begin
            halted_prev <= cpu_halted_in;
        end
    end

    // Conversion sequencer, counted in converter clock periods
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= adc_select_pkg::CONV_IDLE;
            cycle_count <= 5'h00;
            conv_len <= adc_select_pkg::NORMAL_CYCLES;
            first_pending <= 1'b1;
        end else begin
            case (state)
                adc_select_pkg::CONV_IDLE: begin
                    if (!converter_enable_bit) begin
                        first_pending <= 1'b1;
                    end else if (start_now) begin // RULE5
                        state <= adc_select_pkg::CONV_BUSY;
                        cycle_count <= 5'h01;
                        conv_len <= first_pending ? adc_select_pkg::FIRST_CYCLES :
                                    adc_select_pkg::NORMAL_CYCLES; // RULE21
                        first_pending <= 1'b0;
                    end
                end
                adc_select_pkg::CONV_BUSY: begin
                    if (!converter_enable_bit) begin
                        state <= adc_select_pkg::CONV_IDLE;
                        first_pending <= 1'b1;
                    end else if (restart) begin // RULE10
                        cycle_count <= 5'h01;
                        conv_len <= adc_select_pkg::NORMAL_CYCLES;
                    end else if (complete) begin
                        state <= adc_select_pkg::CONV_IDLE;
                    end else if (adc_tick) begin
                        cycle_count <= cycle_count + 5'h01;
                    end
                end
                default: begin
                    state <= adc_select_pkg::CONV_IDLE;
                end
            endcase
        end
    end

    // Result capture at completion
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            result <= 10'h000;
        end else if (complete) begin // RULE22
            if (is_single_ended(active_channel) && above_sync) begin
                result <= adc_select_pkg::FULL_SCALE; // RULE12
            end else begin
                result <= analog_sync;
            end
        end
    end

    // APB read data, captured in the setup cycle; left adjust applies at read time
    always_comb begin
        next_prdata = 32'h0000_0000;
        case (paddr_in)
            adc_select_pkg::SELECT_OFFSET: begin
                next_prdata[7:0] = {reference_select_bits, left_adjust, channel_select_bits};
            end
            adc_select_pkg::CONTROL_OFFSET: begin
                next_prdata[7:0] = {converter_enable_bit, conversion_start_bit,
                                    free_running_select_bit, conversion_done_flag,
                                    complete_irq_enable, prescale_select};
            end
            adc_select_pkg::RESULT_OFFSET: begin
                next_prdata[15:0] = left_adjust ? {result, 6'h00} : {6'h00, result};
            end
            adc_select_pkg::STATUS_OFFSET: begin
                next_prdata[adc_select_pkg::CHANNEL_MSB:0] = active_channel;
                next_prdata[adc_select_pkg::STATUS_REF_LSB +: 2] = active_reference;
                next_prdata[adc_select_pkg::STATUS_LOCKED_BIT] = !unlocked;
                next_prdata[adc_select_pkg::STATUS_FIRST_BIT] = first_pending;
                next_prdata[adc_select_pkg::STATUS_JTAG_BIT] = jtag_sync;
            end
            default: begin
                next_prdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in) begin
            prdata_out <= next_prdata;
        end
    end

    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in &&
                         (paddr_in != adc_select_pkg::SELECT_OFFSET) &&
                         (paddr_in != adc_select_pkg::CONTROL_OFFSET) &&
                         (paddr_in != adc_select_pkg::RESULT_OFFSET) &&
                         (paddr_in != adc_select_pkg::STATUS_OFFSET);

    // Reference switches decoded from the active selection; code 10 selects nothing
    assign ref_external_out = (active_reference == adc_select_pkg::REF_EXTERNAL); // RULE13 RULE23
    assign ref_supply_out = (active_reference == adc_select_pkg::REF_SUPPLY); // RULE23
    assign ref_internal_out = (active_reference == adc_select_pkg::REF_INTERNAL); // RULE23
    assign mux_connect_out = converter_enable_bit &&
                             !(jtag_sync && is_jtag_channel(active_channel)); // RULE9
    assign active_channel_out = active_channel;
    assign active_reference_out = active_reference;
    assign converter_busy_out = busy;
    assign conv_complete_irq_out = conversion_done_flag && complete_irq_enable; // RULE16

    // Checks
    logic [5:0] ticks_seen;
    logic expect_first;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ticks_seen <= 6'h00;
            expect_first <= 1'b0;
        end else if (start_now || restart) begin
            ticks_seen <= 6'h01;
            expect_first <= start_now && first_pending;
        end else if (adc_tick && busy) begin
            ticks_seen <= ticks_seen + 6'h01;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_start_edge;
        start_now;
    endsequence
    sequence s_single_done;
        complete && !free_running_select_bit;
    endsequence

    a_start_on_tick: assert property (s_start_edge |=> busy && (cycle_count == 5'h01)) // RULE5
        else $error("conversion did not begin on converter clock edge");
    a_idle_copy: assert property (!busy |=> {active_channel, active_reference} == // RULE2
                                  $past({channel_select_bits, reference_select_bits}))
        else $error("idle selection not copied");
    a_frozen_select: assert property (!unlocked |=> $stable(active_channel) && // RULE3
                                      $stable(active_reference))
        else $error("active selection changed while locked");
    a_final_resume: assert property (busy && (cycle_count == conv_len) |=> // RULE4
                                     active_channel == $past(channel_select_bits))
        else $error("selection not resumed in final cycle");
    a_conv_length: assert property (complete |-> ticks_seen == // RULE21
                                    (expect_first ? 6'h19 : 6'h0d))
        else $error("conversion length wrong");
    a_done_start: assert property (s_single_done |=> conversion_done_flag && // RULE22
                                   !conversion_start_bit && !busy)
        else $error("single completion did not set done and clear start");
    a_free_restart: assert property (restart |=> busy && conversion_start_bit && // RULE10
                                     (conv_len == 5'h0d))
        else $error("free running did not restart");
    a_jtag_override: assert property (jtag_sync && is_jtag_channel(active_channel) |-> // RULE9
                                      !mux_connect_out)
        else $error("jtag channel still connected");
    a_auto_start: assert property (auto_start |=> conversion_start_bit ##[1:256] busy) // RULE15
        else $error("noise canceler did not start conversion");
    a_full_scale: assert property (complete && above_sync && // RULE12
                                   is_single_ended(active_channel) |=> result == 10'h3ff)
        else $error("over reference input not full scale");
    a_ref_decode: assert property ((active_reference == 2'h2) |-> // RULE23
                                   !(ref_external_out || ref_supply_out || ref_internal_out))
        else $error("reserved reference selected a source");
endmodule
`default_nettype wire

// ===== common/adc_select_pkg.sv
// Package: register map, field layout, timing counts and state codes of the converter control
`default_nettype none
package adc_select_pkg;
    // Register byte offsets
    localparam logic [7:0] SELECT_OFFSET = 8'h00;
    localparam logic [7:0] CONTROL_OFFSET = 8'h04;
    localparam logic [7:0] RESULT_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0c;
    // Select register fields
    localparam int REF_MSB = 7;
    localparam int REF_LSB = 6;
    localparam int LEFT_ADJUST_BIT = 5;
    localparam int CHANNEL_MSB = 4;
    // Control register fields
    localparam int ENABLE_BIT = 7;
    localparam int START_BIT = 6;
    localparam int FREE_RUN_BIT = 5;
    localparam int DONE_BIT = 4;
    localparam int IRQ_ENABLE_BIT = 3;
    localparam int PRESCALE_MSB = 2;
    // Status register fields
    localparam int STATUS_REF_LSB = 6;
    localparam int STATUS_LOCKED_BIT = 8;
    localparam int STATUS_FIRST_BIT = 9;
    localparam int STATUS_JTAG_BIT = 10;
    // Reset values
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // Conversion lengths in converter clock periods, then the full-scale result code
    localparam logic [4:0] NORMAL_CYCLES = 5'h0d;
    localparam logic [4:0] FIRST_CYCLES = 5'h19;
    localparam logic [9:0] FULL_SCALE = 10'h3ff;
    // Reference select encoding
    localparam logic [1:0] REF_EXTERNAL = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_INTERNAL = 2'h3;
    // Sleep mode codes seen on the sleep mode input
    localparam logic [2:0] SLEEP_IDLE = 3'h0;
    localparam logic [2:0] SLEEP_NOISE_REDUCTION = 3'h1;
    // Single-ended channel codes: 0..7 plus the two fixed inputs
    localparam logic [4:0] LAST_PIN_CHANNEL = 5'h07;
    localparam logic [4:0] FIRST_FIXED_CHANNEL = 5'h1e;
    localparam logic [4:0] FIRST_JTAG_CHANNEL = 5'h04;
    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_BUSY = 2'b10
    } conv_state_type;
endpackage
`default_nettype wire

// ===== src/adc_clock_prescaler.sv
// Converter clock prescaler: one-cycle tick per converter clock rising edge
`default_nettype none
module adc_clock_prescaler (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic [2:0] divide_select_in,
    output logic tick_out
);
    logic [6:0] count;
    logic [6:0] limit;

    // Division is 2 to the power of the select, with select 0 also dividing by 2
    always_comb begin
        limit = 7'h01;
        if (divide_select_in > 3'h1) begin
            limit = 7'((8'h01 << divide_select_in) - 8'h01);
        end
    end

    // Held in reset while the converter is off
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !run_in) begin
            count <= 7'h00;
        end else if (count >= limit) begin
            count <= 7'h00;
        end else begin
            count <= count + 7'h01;
        end
    end

    assign tick_out = run_in && (count >= limit);
endmodule
`default_nettype wire

// ===== dv/adc_analog_source.sv
// Analog input model: converted level and over-reference flag with settling delay
`default_nettype none
module adc_analog_source (
    input wire logic clk_in,
    input wire logic [9:0] level_in,
    input wire logic over_in,
    output logic [9:0] result_out,
    output logic above_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Source settles one clock after the bench changes it
    // Ideal source: no gain or reference settling, level_in followed on every clock, also during conversions
    always_ff @(posedge clk_in) begin
        result_out <= level_in;
        above_out <= over_in;
    end
endmodule
`default_nettype wire

// ===== dv/adc_select_sync_noise_cancel_tb_top.sv
// Self-checking bench for the converter control block
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module adc_select_sync_noise_cancel_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, rd, prdata_out;
    logic err, pready_out, pslverr_out, cpu_halted = 1'b0, jtag = 1'b0, over = 1'b0;
    logic [2:0] sleep_mode = 3'h0;
    logic [9:0] level = 10'h000, analog_result;
    logic above, ref_ext, ref_sup, ref_int, mux_connect, busy, irq;
    logic [4:0] act_ch;
    logic [1:0] act_ref;
    int fail_count = 0, checks = 0, n, seed = 32'h11bd;
    int exp_q[$];
    int conv_clks = 0, last_len = 0;
    always #2.5 clk_in = ~clk_in;
    // Length of the last unbroken busy stretch, in system clocks
    always @(posedge clk_in) begin
        conv_clks <= (busy === 1'b1) ? conv_clks + 1 : 0;
        if (busy !== 1'b1 && conv_clks != 0) last_len <= conv_clks;
    end
    adc_analog_source src_u (.clk_in(clk_in), .level_in(level), .over_in(over),
        .result_out(analog_result), .above_out(above));
    adc_select_sync_noise_cancel dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .sleep_mode_in(sleep_mode), .cpu_halted_in(cpu_halted), .jtag_enable_in(jtag),
        .analog_result_in(analog_result), .above_reference_in(above),
        .active_channel_out(act_ch), .active_reference_out(act_ref), .ref_external_out(ref_ext),
        .ref_supply_out(ref_sup), .ref_internal_out(ref_int), .mux_connect_out(mux_connect),
        .converter_busy_out(busy), .conv_complete_irq_out(irq));
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_in);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits for busy to rise and fall; n is then the busy time in system clocks
    task automatic run_conv();
        n = 0;
        while (busy !== 1'b1 && n < 400) begin @(posedge clk_in); n++; end
        n = 0;
        while (busy === 1'b1 && n < 400) begin @(posedge clk_in); n++; end
        repeat (3) @(posedge clk_in);
        n = last_len;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        apb(1'b0, adc_select_pkg::SELECT_OFFSET, 32'h0);
        `CHK("select reset", 32'h00000000, rd)
        `CHK("ext ref reset", 1'b1, ref_ext)
        $display("test reset done");
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, adc_select_pkg::SELECT_OFFSET, 32'(r * 64 + 2));
            apb(1'b0, adc_select_pkg::SELECT_OFFSET, 32'h0);
            `CHK("select back", 32'(r * 64 + 2), rd)
            `CHK("active ref", 2'(r), act_ref)
            `CHK("ext ref", (r == 0), ref_ext)
            `CHK("supply ref", (r == 1), ref_sup)
            `CHK("internal ref", (r == 3), ref_int)
        end
        $display("test reference decode done");
        level <= 10'($random(seed));
        // Single-ended channels only, so no gain settling wait is due
        apb(1'b1, adc_select_pkg::SELECT_OFFSET, 32'h43);
        exp_q.push_back(int'(level));
        apb(1'b1, adc_select_pkg::CONTROL_OFFSET, 32'hc0);
        while (busy !== 1'b1) @(posedge clk_in);
        apb(1'b1, adc_select_pkg::SELECT_OFFSET, 32'hc6);
        `CHK("locked channel", 5'h03, act_ch)
        `CHK("locked ref", 2'h1, act_ref)
        apb(1'b0, adc_select_pkg::STATUS_OFFSET, 32'h0);
        `CHK("status locked", 32'h00000143, rd)
        run_conv();
        `CHK("first length", 50, n)
        `CHK("new channel", 5'h06, act_ch)
        apb(1'b0, adc_select_pkg::CONTROL_OFFSET, 32'h0);
        `CHK("start cleared", 1'b0, rd[6])
        `CHK("done set", 1'b1, rd[4])
        apb(1'b0, adc_select_pkg::RESULT_OFFSET, 32'h0);
        `CHK("result", 32'(exp_q.pop_front()), rd)
        over <= 1'b1;
        apb(1'b1, adc_select_pkg::CONTROL_OFFSET, 32'hd0);
        run_conv();
        `CHK("normal length", 26, n)
        apb(1'b0, adc_select_pkg::RESULT_OFFSET, 32'h0);
        `CHK("full scale", 32'h3ff, rd)
        apb(1'b1, adc_select_pkg::SELECT_OFFSET, 32'h66);
        apb(1'b0, adc_select_pkg::RESULT_OFFSET, 32'h0);
        `CHK("left adjust", 32'h0000ffc0, rd)
        over <= 1'b0;
        $display("test conversions done");
        apb(1'b1, adc_select_pkg::SELECT_OFFSET, 32'h41);
        apb(1'b1, adc_select_pkg::CONTROL_OFFSET, 32'he0);
        while (busy !== 1'b1) @(posedge clk_in);
        repeat (30) @(posedge clk_in);
        apb(1'b1, adc_select_pkg::SELECT_OFFSET, 32'h44);
        `CHK("free run old channel", 5'h01, act_ch)
        repeat (26) @(posedge clk_in);
        `CHK("free run new channel", 5'h04, act_ch)
        apb(1'b1, adc_select_pkg::CONTROL_OFFSET, 32'h80);
        run_conv();
        `CHK("free run length", 78, n)
        $display("test free running done");
        jtag <= 1'b1;
        apb(1'b1, adc_select_pkg::SELECT_OFFSET, 32'h45);
        repeat (4) @(posedge clk_in);
        `CHK("jtag upper pin", 1'b0, mux_connect)
        apb(1'b1, adc_select_pkg::SELECT_OFFSET, 32'h42);
        repeat (4) @(posedge clk_in);
        `CHK("jtag lower pin", 1'b1, mux_connect)
        jtag <= 1'b0;
        $display("test jtag done");
        sleep_mode <= 3'h2;
        cpu_halted <= 1'b1;
        repeat (8) @(posedge clk_in);
        `CHK("deep sleep idle", 1'b0, busy)
        // No differential conversion follows, so no enable cycling is due
        cpu_halted <= 1'b0;
        apb(1'b0, adc_select_pkg::CONTROL_OFFSET, 32'h0);
        `CHK("deep sleep enable", 1'b1, rd[7])
        apb(1'b1, adc_select_pkg::CONTROL_OFFSET, 32'h98);
        sleep_mode <= adc_select_pkg::SLEEP_NOISE_REDUCTION;
        cpu_halted <= 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 40) begin @(posedge clk_in); n++; end
        `CHK("sleep start", 1'b1, busy)
        `CHK("irq pending", 1'b0, irq)
        cpu_halted <= 1'b0;
        run_conv();
        `CHK("noise length", 26, n)
        `CHK("irq after wake", 1'b1, irq)
        $display("test noise canceler done");
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        $display("test unmapped done");
        give_verdict();
    end
endmodule
`default_nettype wire
